/* logic/crs_regset.sv */
`timescale 1ns/1ps

// Functional notes
// - sixteen registers, register zero is stack pointer
// - status bit selects interrupt or user stack
// - vector table base locates interrupt vectors
// - program counter holds executing instruction address
// - status word reflects results and cpu state
// - fast interrupt saves program counter
// - fast interrupt saves status word, same layout
// - fast interrupt branches to fast vector register
// - 64-bit accumulator for dsp instructions
// - multiply instructions overwrite or accumulate accumulator
// - half writes load high or low word
// - reads return high word or middle word

module crs_regset
   import crs_pkg::*;
(
   // clock, reset and enable
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // general register write
   input wire logic gpr_wr_en_in,
   input wire logic [GPR_IDX_W-1:0] gpr_wr_idx_in,
   input wire logic [WORD_W-1:0] gpr_wr_data_in,
   // general register read
   input wire logic [GPR_IDX_W-1:0] gpr_rd_idx_in,
   output logic [WORD_W-1:0] gpr_rd_data_out,
   // control register access
   input wire logic ctl_wr_en_in,
   input wire crs_ctl_sel_t ctl_wr_sel_in,
   input wire logic [WORD_W-1:0] ctl_wr_data_in,
   input wire crs_ctl_sel_t ctl_rd_sel_in,
   output logic [WORD_W-1:0] ctl_rd_data_out,
   // fast interrupt entry and return
   input wire logic fast_int_accept_in,
   input wire logic fast_int_return_in,
   // relocatable vector lookup
   input wire logic vec_req_in,
   input wire logic [VEC_NUM_W-1:0] vec_num_in,
   output logic [WORD_W-1:0] vec_addr_out,
   output logic vec_valid_out,
   // accumulator operations
   input wire crs_acc_op_t acc_op_in,
   input wire logic [WORD_W-1:0] acc_word_in,
   input wire logic [ACC_W-1:0] acc_product_in,
   output logic [ACC_W-1:0] acc_value_out,
   output logic [WORD_W-1:0] acc_rd_data_out,
   // live state toward execution
   output logic [WORD_W-1:0] program_counter_out,
   output logic [WORD_W-1:0] processor_status_word_out
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // true when a general write lands on register index i
   function automatic logic gpr_hit(input logic en,
                                    input logic [GPR_IDX_W-1:0] idx,
                                    input logic [GPR_IDX_W-1:0] i);
      gpr_hit = en && (idx == i);
   endfunction

   // true when a control write selects the given register
   function automatic logic ctl_hit(input logic en,
                                    input crs_ctl_sel_t sel,
                                    input crs_ctl_sel_t which);
      ctl_hit = en && (sel == which);
   endfunction

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [WORD_W-1:0] gpr [GPR_COUNT]; // index 0 unused, see stacks
   logic [WORD_W-1:0] interrupt_stack_pointer; // stack in supervisor
   logic [WORD_W-1:0] user_stack_pointer; // stack in user mode
   logic [WORD_W-1:0] vector_table_base; // start of vector table
   logic [WORD_W-1:0] saved_program_counter; // copy for fast return
   logic [WORD_W-1:0] saved_status_word; // copy for fast return
   logic [WORD_W-1:0] fast_vector_address; // fast interrupt target
   logic stack_sel_user; // current stack choice
   logic sp_wr; // general write aimed at the stack pointer

   assign stack_sel_user = processor_status_word_out[PSW_U_BIT];
   assign sp_wr = gpr_hit(gpr_wr_en_in, gpr_wr_idx_in, SP_IDX);
   assign gpr[0] = WORD_RST;

   // ---------------------------------------------------------------
   // general registers one to fifteen
   // ---------------------------------------------------------------
   // each register is its own flop bank; index 0 is handled below
   for (genvar i = 1; i < GPR_COUNT; i++)
   begin : g_gpr
      always_ff @(posedge ref_clk_in or negedge rst_n_in)
      begin
         if (!rst_n_in)
            gpr[i] <= WORD_RST;
         else if (clk_en_in &&
                  gpr_hit(gpr_wr_en_in, gpr_wr_idx_in,
                          GPR_IDX_W'(i)))
            gpr[i] <= gpr_wr_data_in;
      end
   end

   // ---------------------------------------------------------------
   // stack pointers
   // ---------------------------------------------------------------
   // register zero writes follow the select bit; a control write to
   // the same stack in the same cycle loses, as it is the rarer path.
   // alignment is left to software, the low bits are stored as given.
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         interrupt_stack_pointer <= WORD_RST;
      else if (clk_en_in)
      begin
         if (sp_wr && !stack_sel_user)
            interrupt_stack_pointer <= gpr_wr_data_in;
         else if (ctl_hit(ctl_wr_en_in, ctl_wr_sel_in, CTL_ISP))
            interrupt_stack_pointer <= ctl_wr_data_in;
      end
   end

   // user stack, same priority as above
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         user_stack_pointer <= WORD_RST;
      else if (clk_en_in)
      begin
         if (sp_wr && stack_sel_user)
            user_stack_pointer <= gpr_wr_data_in;
         else if (ctl_hit(ctl_wr_en_in, ctl_wr_sel_in, CTL_USP))
            user_stack_pointer <= ctl_wr_data_in;
      end
   end

   // ---------------------------------------------------------------
   // plain control registers
   // ---------------------------------------------------------------
   // table base and fast vector change only by explicit writes
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         vector_table_base <= WORD_RST;
         fast_vector_address <= WORD_RST;
      end
      else if (clk_en_in)
      begin
         if (ctl_hit(ctl_wr_en_in, ctl_wr_sel_in, CTL_VECTOR_TABLE_BASE))
            vector_table_base <= ctl_wr_data_in;
         if (ctl_hit(ctl_wr_en_in, ctl_wr_sel_in, CTL_FAST_VECTOR_ADDRESS))
            fast_vector_address <= ctl_wr_data_in;
      end
   end

   // ---------------------------------------------------------------
   // program counter
   // ---------------------------------------------------------------
   // interrupt entry beats return, which beats a normal pc load
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         program_counter_out <= WORD_RST;
      else if (clk_en_in)
      begin
         if (fast_int_accept_in)
            program_counter_out <= fast_vector_address;
         else if (fast_int_return_in)
            program_counter_out <= saved_program_counter;
         else if (ctl_hit(ctl_wr_en_in, ctl_wr_sel_in, CTL_PC))
            program_counter_out <= ctl_wr_data_in;
      end
   end

   // ---------------------------------------------------------------
   // status word
   // ---------------------------------------------------------------
   // execution writes results and state; return restores the copy in
   // the same edge as the program counter so no mixed state is seen
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         processor_status_word_out <= WORD_RST;
      else if (clk_en_in)
      begin
         if (fast_int_return_in && !fast_int_accept_in)
            processor_status_word_out <= saved_status_word;
         else if (ctl_hit(ctl_wr_en_in, ctl_wr_sel_in, CTL_PSW))
            processor_status_word_out <= ctl_wr_data_in;
      end
   end

   // ---------------------------------------------------------------
   // fast interrupt backups
   // ---------------------------------------------------------------
   // the accept snapshot wins over a software write in the same cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         saved_program_counter <= WORD_RST;
         saved_status_word <= WORD_RST;
      end
      else if (clk_en_in)
      begin
         if (fast_int_accept_in)
         begin
            saved_program_counter <= program_counter_out;
            saved_status_word <= processor_status_word_out;
         end
         else
         begin
            if (ctl_hit(ctl_wr_en_in, ctl_wr_sel_in, CTL_BPC))
               saved_program_counter <= ctl_wr_data_in;
            if (ctl_hit(ctl_wr_en_in, ctl_wr_sel_in, CTL_SAVED_STATUS_WORD))
               saved_status_word <= ctl_wr_data_in;
         end
      end
   end

   // ---------------------------------------------------------------
   // read ports
   // ---------------------------------------------------------------
   // register zero reads whichever stack the select bit names
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         gpr_rd_data_out <= WORD_RST;
      else if (clk_en_in)
      begin
         if (gpr_rd_idx_in == SP_IDX)
            gpr_rd_data_out <= stack_sel_user ? user_stack_pointer :
                               interrupt_stack_pointer;
         else
            gpr_rd_data_out <= gpr[gpr_rd_idx_in];
      end
   end

   // control register read, old value if written in the same cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         ctl_rd_data_out <= WORD_RST;
      else if (clk_en_in)
      begin
         case (ctl_rd_sel_in)
            CTL_ISP: ctl_rd_data_out <= interrupt_stack_pointer;
            CTL_USP: ctl_rd_data_out <= user_stack_pointer;
            CTL_VECTOR_TABLE_BASE: ctl_rd_data_out <= vector_table_base;
            CTL_PC: ctl_rd_data_out <= program_counter_out;
            CTL_PSW: ctl_rd_data_out <= processor_status_word_out;
            CTL_BPC: ctl_rd_data_out <= saved_program_counter;
            CTL_SAVED_STATUS_WORD: ctl_rd_data_out <= saved_status_word;
            CTL_FAST_VECTOR_ADDRESS: ctl_rd_data_out <= fast_vector_address;
            default: ctl_rd_data_out <= WORD_RST;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // vector lookup
   // ---------------------------------------------------------------
   // entry address is base plus four times the vector number
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         vec_addr_out <= WORD_RST;
         vec_valid_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         vec_valid_out <= vec_req_in;
         if (vec_req_in)
            vec_addr_out <= vector_table_base +
               (WORD_W'(vec_num_in) << VEC_SHIFT);
      end
   end

   // ---------------------------------------------------------------
   // accumulator
   // ---------------------------------------------------------------
   // kept in its own unit so the dsp datapath can grow separately
   crs_acc u_acc (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .acc_op_in(acc_op_in),
      .acc_word_in(acc_word_in),
      .acc_product_in(acc_product_in),
      .acc_value_out(acc_value_out),
      .acc_rd_data_out(acc_rd_data_out)
   );

endmodule

/* logic/crs_pkg.sv */
package crs_pkg;

   // ---------------------------------------------------------------
   // widths and counts
   // ---------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam int ACC_W = 64;
   localparam int GPR_COUNT = 16;
   localparam int GPR_IDX_W = 4;
   localparam int VEC_NUM_W = 8;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   // stack pointer select bit inside the status word
   localparam int PSW_U_BIT = 17;
   // accumulator halves and middle word
   localparam int ACC_HI_MSB = 63;
   localparam int ACC_HI_LSB = 32;
   localparam int ACC_LO_MSB = 31;
   localparam int ACC_LO_LSB = 0;
   localparam int ACC_MID_MSB = 47;
   localparam int ACC_MID_LSB = 16;
   // vector table entries are one word, so the number shifts by two
   localparam int VEC_SHIFT = 2;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
   localparam logic [ACC_W-1:0] ACC_RST = 64'h0000_0000_0000_0000;
   localparam logic [GPR_IDX_W-1:0] SP_IDX = 4'h0;

   // ---------------------------------------------------------------
   // control register select codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CTL_ISP,
      CTL_USP,
      CTL_VECTOR_TABLE_BASE,
      CTL_PC,
      CTL_PSW,
      CTL_BPC,
      CTL_SAVED_STATUS_WORD,
      CTL_FAST_VECTOR_ADDRESS
   } crs_ctl_sel_t;

   // ---------------------------------------------------------------
   // accumulator operations
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ACC_NOP,
      ACC_WR_HI,
      ACC_WR_LO,
      ACC_PROD_LOAD,
      ACC_PROD_SUM,
      ACC_RD_HI,
      ACC_RD_MID
   } crs_acc_op_t;

endpackage

/* logic/crs_acc.sv */
`timescale 1ns/1ps

module crs_acc
   import crs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // operation request
   input wire crs_acc_op_t acc_op_in,
   input wire logic [WORD_W-1:0] acc_word_in,
   input wire logic [ACC_W-1:0] acc_product_in,
   // results
   output logic [ACC_W-1:0] acc_value_out,
   output logic [WORD_W-1:0] acc_rd_data_out
);

   // ---------------------------------------------------------------
   // accumulator storage
   // ---------------------------------------------------------------
   // the accumulator itself; the output is the flop
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         acc_value_out <= ACC_RST;
      else if (clk_en_in)
      begin
         case (acc_op_in)
            // half writes keep the other half intact
            ACC_WR_HI:
               acc_value_out[ACC_HI_MSB:ACC_HI_LSB] <= acc_word_in;
            ACC_WR_LO:
               acc_value_out[ACC_LO_MSB:ACC_LO_LSB] <= acc_word_in;
            // wide and plain multiply overwrite the old value
            ACC_PROD_LOAD:
               acc_value_out <= acc_product_in;
            // repeated multiply-accumulate adds; carry out of 64 is lost
            ACC_PROD_SUM:
               acc_value_out <= acc_value_out + acc_product_in;
            default:
               acc_value_out <= acc_value_out;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // registered read, so the word lands one cycle after the request
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         acc_rd_data_out <= WORD_RST;
      else if (clk_en_in)
      begin
         case (acc_op_in)
            ACC_RD_HI:
               acc_rd_data_out <= acc_value_out[ACC_HI_MSB:ACC_HI_LSB];
            ACC_RD_MID:
               acc_rd_data_out <= acc_value_out[ACC_MID_MSB:ACC_MID_LSB];
            default:
               acc_rd_data_out <= acc_rd_data_out;
         endcase
      end
   end

endmodule

/* verif/crs_mul_model.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// multiplier standing in for the execution side
// ---------------------------------------------------------------
module crs_mul_model
   import crs_pkg::*;
(
   // operands
   input wire logic [WORD_W-1:0] mul_a_in,
   input wire logic [WORD_W-1:0] mul_b_in,
   input wire logic mul_signed_in,
   // product toward the accumulator
   output logic [ACC_W-1:0] product_out
);
   logic [ACC_W-1:0] ext_a; // operand a widened
   logic [ACC_W-1:0] ext_b; // operand b widened
   // sign or zero extension makes the low 64 bits right for both kinds
   assign ext_a = {mul_signed_in ? {32{mul_a_in[31]}} : 32'h0, mul_a_in};
   assign ext_b = {mul_signed_in ? {32{mul_b_in[31]}} : 32'h0, mul_b_in};
   assign product_out = ext_a * ext_b;
endmodule

/* verif/crs_props.sv */
`timescale 1ns/1ps

module crs_props
   import crs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // requests
   input wire logic ctl_wr_en_in,
   input wire logic fast_int_accept_in,
   input wire logic fast_int_return_in,
   input wire logic vec_req_in,
   input wire crs_acc_op_t acc_op_in,
   input wire logic [WORD_W-1:0] acc_word_in,
   input wire logic [ACC_W-1:0] acc_product_in,
   // results
   input wire logic vec_valid_out,
   input wire logic [ACC_W-1:0] acc_value_out,
   input wire logic [WORD_W-1:0] acc_rd_data_out,
   input wire logic [WORD_W-1:0] program_counter_out,
   input wire logic [WORD_W-1:0] processor_status_word_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // ---------------------------------------------------------------
   // fast interrupt round trip
   // ---------------------------------------------------------------
   // control writes are kept out so the saved copies are unambiguous
   sequence s_enter;
      clk_en_in && fast_int_accept_in && !ctl_wr_en_in;
   endsequence
   sequence s_leave;
      clk_en_in && fast_int_return_in && !fast_int_accept_in && !ctl_wr_en_in;
   endsequence
   property p_fast_round;
      s_enter ##1 s_leave |=>
         program_counter_out == $past(program_counter_out, 2) &&
         processor_status_word_out == $past(processor_status_word_out, 2);
   endproperty
   a_fast_round: assert property (p_fast_round)
      else $error("fast return did not restore state");
   // ---------------------------------------------------------------
   // accumulator
   // ---------------------------------------------------------------
   property p_acc_hi;
      clk_en_in && acc_op_in == ACC_WR_HI |=>
         acc_value_out == {$past(acc_word_in), $past(acc_value_out[31:0])};
   endproperty
   a_acc_hi: assert property (p_acc_hi)
      else $error("high half write wrong");
   property p_acc_lo;
      clk_en_in && acc_op_in == ACC_WR_LO |=>
         acc_value_out == {$past(acc_value_out[63:32]), $past(acc_word_in)};
   endproperty
   a_acc_lo: assert property (p_acc_lo)
      else $error("low half write wrong");
   property p_acc_load;
      clk_en_in && acc_op_in == ACC_PROD_LOAD |=>
         acc_value_out == $past(acc_product_in);
   endproperty
   a_acc_load: assert property (p_acc_load)
      else $error("product load wrong");
   property p_acc_sum;
      clk_en_in && acc_op_in == ACC_PROD_SUM |=>
         acc_value_out == $past(acc_value_out) + $past(acc_product_in);
   endproperty
   a_acc_sum: assert property (p_acc_sum)
      else $error("product sum wrong");
   property p_acc_rdhi;
      clk_en_in && acc_op_in == ACC_RD_HI |=>
         acc_rd_data_out == $past(acc_value_out[63:32]);
   endproperty
   a_acc_rdhi: assert property (p_acc_rdhi)
      else $error("high read wrong");
   property p_acc_mid;
      clk_en_in && acc_op_in == ACC_RD_MID |=>
         acc_rd_data_out == $past(acc_value_out[47:16]);
   endproperty
   a_acc_mid: assert property (p_acc_mid)
      else $error("middle read wrong");
   // frozen enable must hold the accumulator and the program counter
   property p_freeze;
      !clk_en_in |=> $stable(acc_value_out) && $stable(program_counter_out);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while frozen");
   property p_vec_pulse;
      vec_valid_out && $past(clk_en_in) |-> $past(vec_req_in);
   endproperty
   a_vec_pulse: assert property (p_vec_pulse)
      else $error("lookup valid without request");
endmodule

bind crs_regset crs_props u_props (.*);

/* verif/cpu_register_set_tb_top.sv */
`timescale 1ns/1ps

module cpu_register_set_tb_top;
   import crs_pkg::*;
   // ---------------------------------------------------------------
   // design ports, driven on the falling edge
   // ---------------------------------------------------------------
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic clk_en_in = 1'b1;
   logic gpr_wr_en_in = 1'b0;
   logic [3:0] gpr_wr_idx_in = 4'h0;
   logic [31:0] gpr_wr_data_in = 32'h0;
   logic [3:0] gpr_rd_idx_in = 4'h0;
   logic [31:0] gpr_rd_data_out;
   logic ctl_wr_en_in = 1'b0;
   crs_ctl_sel_t ctl_wr_sel_in = CTL_ISP;
   logic [31:0] ctl_wr_data_in = 32'h0;
   crs_ctl_sel_t ctl_rd_sel_in = CTL_ISP;
   logic [31:0] ctl_rd_data_out;
   logic fast_int_accept_in = 1'b0;
   logic fast_int_return_in = 1'b0;
   logic vec_req_in = 1'b0;
   logic [7:0] vec_num_in = 8'h0;
   logic [31:0] vec_addr_out;
   logic vec_valid_out;
   crs_acc_op_t acc_op_in = ACC_NOP;
   logic [31:0] acc_word_in = 32'h0;
   logic [63:0] acc_product_in;
   logic [63:0] acc_value_out;
   logic [31:0] acc_rd_data_out;
   logic [31:0] program_counter_out;
   logic [31:0] processor_status_word_out;
   logic [31:0] mul_a = 32'h0; // multiplier operands
   logic [31:0] mul_b = 32'h0;
   logic mul_sg = 1'b0;
   logic [31:0] rd; // last readback
   int n_mismatch = 0;
   int n_checks = 0;

   crs_regset DUT (.*);
   crs_mul_model u_mul (.mul_a_in(mul_a), .mul_b_in(mul_b),
      .mul_signed_in(mul_sg), .product_out(acc_product_in));

   always #25 ref_clk_in = ~ref_clk_in;

   // ---------------------------------------------------------------
   // shared tasks; write tasks idle one cycle so strobes never bounce
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_ctl(input crs_ctl_sel_t s, input logic [31:0] d);
      ctl_wr_sel_in = s;
      ctl_wr_data_in = d;
      ctl_wr_en_in = 1'b1;
      @(negedge ref_clk_in);
      ctl_wr_en_in = 1'b0;
      @(negedge ref_clk_in);
   endtask
   task automatic rd_ctl(input crs_ctl_sel_t s);
      ctl_rd_sel_in = s;
      @(negedge ref_clk_in);
      rd = ctl_rd_data_out;
   endtask
   task automatic wr_gpr(input logic [3:0] i, input logic [31:0] d);
      gpr_wr_idx_in = i;
      gpr_wr_data_in = d;
      gpr_wr_en_in = 1'b1;
      @(negedge ref_clk_in);
      gpr_wr_en_in = 1'b0;
      @(negedge ref_clk_in);
   endtask
   task automatic rd_gpr(input logic [3:0] i);
      gpr_rd_idx_in = i;
      @(negedge ref_clk_in);
      rd = gpr_rd_data_out;
   endtask
   task automatic acc_do(input crs_acc_op_t op, input logic [31:0] w);
      acc_op_in = op;
      acc_word_in = w;
      @(negedge ref_clk_in);
      acc_op_in = ACC_NOP;
      @(negedge ref_clk_in);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_gpr;
      for (int i = 1; i < 16; i++)
         wr_gpr(4'(i), 32'h1111_0000 + 32'(i));
      for (int i = 1; i < 16; i++)
      begin
         rd_gpr(4'(i));
         chk("gpr", rd, 32'h1111_0000 + 32'(i));
      end
      $display("test gpr done");
   endtask
   task automatic t_stack;
      // stack values kept word aligned
      wr_ctl(CTL_ISP, 32'h0000_0100);
      wr_ctl(CTL_USP, 32'h0000_0200);
      wr_ctl(CTL_PSW, 32'h0000_0000);
      rd_gpr(4'h0);
      chk("sp isp", rd, 32'h0000_0100);
      wr_ctl(CTL_PSW, 32'h0002_0000);
      rd_gpr(4'h0);
      chk("sp usp", rd, 32'h0000_0200);
      wr_gpr(4'h0, 32'h0000_0300);
      rd_ctl(CTL_USP);
      chk("usp", rd, 32'h0000_0300);
      rd_ctl(CTL_ISP);
      chk("isp", rd, 32'h0000_0100);
      $display("test stack done");
   endtask
   task automatic t_vec;
      wr_ctl(CTL_VECTOR_TABLE_BASE, 32'h0000_4000);
      vec_num_in = 8'hFF;
      vec_req_in = 1'b1;
      @(negedge ref_clk_in);
      vec_req_in = 1'b0;
      chk("vec valid", vec_valid_out, 1'b1);
      chk("vec addr", vec_addr_out, 32'h0000_43FC);
      @(negedge ref_clk_in);
      chk("vec pulse", vec_valid_out, 1'b0);
      rd_ctl(CTL_VECTOR_TABLE_BASE);
      chk("table base", rd, 32'h0000_4000);
      $display("test vector done");
   endtask
   task automatic t_fast;
      wr_ctl(CTL_FAST_VECTOR_ADDRESS, 32'h0000_8000);
      wr_ctl(CTL_PC, 32'h0000_1000);
      wr_ctl(CTL_PSW, 32'h0002_0005);
      chk("pc", program_counter_out, 32'h0000_1000);
      chk("psw", processor_status_word_out, 32'h0002_0005);
      // return straight after entry is the tightest case
      fast_int_accept_in = 1'b1;
      @(negedge ref_clk_in);
      fast_int_accept_in = 1'b0;
      fast_int_return_in = 1'b1;
      chk("fast pc", program_counter_out, 32'h0000_8000);
      @(negedge ref_clk_in);
      fast_int_return_in = 1'b0;
      chk("ret pc", program_counter_out, 32'h0000_1000);
      chk("ret psw", processor_status_word_out, 32'h0002_0005);
      rd_ctl(CTL_BPC);
      chk("saved pc", rd, 32'h0000_1000);
      rd_ctl(CTL_SAVED_STATUS_WORD);
      chk("saved psw", rd, 32'h0002_0005);
      rd_ctl(CTL_FAST_VECTOR_ADDRESS);
      chk("fast vec", rd, 32'h0000_8000);
      // the handler changes the status word; return must bring it back
      fast_int_accept_in = 1'b1;
      @(negedge ref_clk_in);
      fast_int_accept_in = 1'b0;
      wr_ctl(CTL_PSW, 32'h0000_0000);
      chk("handler psw", processor_status_word_out, 32'h0000_0000);
      fast_int_return_in = 1'b1;
      @(negedge ref_clk_in);
      fast_int_return_in = 1'b0;
      rd_ctl(CTL_PSW);
      chk("psw back", rd, 32'h0002_0005);
      rd_ctl(CTL_PC);
      chk("pc back", rd, 32'h0000_1000);
      $display("test fast done");
   endtask
   task automatic t_acc;
      acc_do(ACC_WR_HI, 32'h1234_5678);
      acc_do(ACC_WR_LO, 32'h9ABC_DEF0);
      chk("acc", acc_value_out, 64'h1234_5678_9ABC_DEF0);
      acc_do(ACC_RD_MID, 32'h0);
      chk("mid", acc_rd_data_out, 32'h5678_9ABC);
      acc_do(ACC_RD_HI, 32'h0);
      chk("hi", acc_rd_data_out, 32'h1234_5678);
      mul_a = 32'hFFFF_FFFF;
      mul_b = 32'h0000_0003;
      mul_sg = 1'b1;
      acc_do(ACC_PROD_LOAD, 32'h0);
      chk("load", acc_value_out, 64'hFFFF_FFFF_FFFF_FFFD);
      mul_sg = 1'b0;
      acc_do(ACC_PROD_SUM, 32'h0);
      chk("sum wrap", acc_value_out, 64'h0000_0002_FFFF_FFFA);
      clk_en_in = 1'b0;
      acc_do(ACC_WR_HI, 32'hDEAD_BEEF);
      chk("frozen", acc_value_out, 64'h0000_0002_FFFF_FFFA);
      clk_en_in = 1'b1;
      $display("test accumulator done");
   endtask

   // ---------------------------------------------------------------
   // closing and watchdog
   // ---------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // the run needs about 110 cycles; close to twenty times that means a hang
   initial
   begin
      repeat (2000) @(posedge ref_clk_in);
      n_mismatch++;
      end_sim();
   end
   initial
   begin
      repeat (12) @(negedge ref_clk_in);
      rst_n_in = 1'b1;
      t_gpr();
      t_stack();
      t_vec();
      t_fast();
      t_acc();
      end_sim();
   end
endmodule
